// file: src/dtf_pkg.sv
// shared constants for the tagged output fifo sequencer
package dtf_pkg;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h20; // control and status
  localparam logic [7:0] REG_FIFO = 8'h24; // sample push (write only)
  localparam logic [7:0] REG_START = 8'h28; // software start (write only)
  localparam logic [7:0] REG_THRESH = 8'h2C; // below-threshold level
  localparam logic [7:0] REG_PRESCALE = 8'h30; // timer prescaler
  localparam logic [7:0] REG_CONVTIM = 8'h34; // conversion timer
  localparam logic [7:0] REG_COUNT = 8'h38; // fifo fill level (read only)

  // control field positions
  localparam int CTRL_MODE_LSB = 0; // two bit mode
  localparam int CTRL_TRIG_LSB = 2; // two bit trigger select
  localparam int CTRL_IRQ_EN = 4; // below-threshold interrupt enable
  localparam int STAT_EMPTY = 12; // fifo empty
  localparam int STAT_FULL = 13; // fifo full
  localparam int STAT_BELOW = 14; // fewer samples than threshold
  localparam int STAT_RUN = 15; // sequencer running, set in any state but idle
  localparam int START_BIT = 0; // start bit in start register

  // sample layout
  localparam int SMP_DATA_W = 16; // converter code bits 15:0
  localparam int SMP_TAG_LSB = 16; // channel tag 18:16
  localparam int SMP_TAG_W = 3;
  localparam int SMP_EOS = 19; // end of sample flag
  localparam int SMP_W = 20;

  // fifo geometry
  localparam int FIFO_DEPTH = 1024;
  localparam int FIFO_AW = 10;

  // mode field codes
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [1:0] MODE_CONT = 2'h2;
  localparam logic [1:0] MODE_RECYCLE = 2'h3;

  // trigger select codes; 00 and 11 disable
  localparam logic [1:0] TRIG_IN = 2'h1;
  localparam logic [1:0] TRIG_OUT = 2'h2;

  // reset values
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [9:0] THRESH_RST = 10'h000;
  localparam logic [7:0] PRESCALE_RST = 8'h00;
  localparam logic [15:0] CONVTIM_RST = 16'h0000;

  // timer base: 8 MHz from 100 MHz by a fractional step of 2/25
  localparam int CLK_MHZ = 100;
  localparam int BASE_MHZ = 8;
  localparam logic [4:0] FRAC_STEP = 5'(2 * BASE_MHZ / BASE_MHZ);
  localparam logic [4:0] FRAC_DEN = 5'(2 * CLK_MHZ / BASE_MHZ);

  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_READ,
    ST_LATCH
  } dtf_state_e;
endpackage : dtf_pkg

// file: src/dtf_mem.sv
`timescale 1ns/10ps
`default_nettype none
// single port write, registered read sample memory
module dtf_mem #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 1024,
  parameter int AW = 10
) (
  input wire logic clk_in,
  input wire logic we_in,
  input wire logic [AW-1:0] waddr_in,
  input wire logic [WIDTH-1:0] wdata_in,
  input wire logic re_in,
  input wire logic [AW-1:0] raddr_in,
  output logic [WIDTH-1:0] rdata_out
);
  // depth must fill the address space so pointers wrap for free
  if (DEPTH != (1 << AW)) begin : g_bad_depth
    $error("dtf_mem: DEPTH must equal 2**AW");
  end

  logic [WIDTH-1:0] mem [DEPTH]; // storage, no reset on purpose

  // read data always comes out of a register
  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem[waddr_in] <= wdata_in;
    end
    if (re_in) begin
      rdata_out <= mem[raddr_in];
    end
  end
endmodule : dtf_mem
`default_nettype wire

// file: src/dtf_seq.sv
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - channel tag is sample bits 18:16
// - bit 19 ends one update cycle
// - single mode moves one cycle per start
// - untouched channels hold previous value
// - mode 01 selects single cycle
// - single mode ignores conversion timer
// - continuous mode pops until end flag
// - continuous cycles paced by conversion timer
// - mode 10 selects continuous new data
// - first start begins continuous updating
// - 1024 deep fifo, below-threshold interrupt
// - fifo status flags at bits 12, 13, 14
// - mode 00 disables all conversions
// - mode 11 recycles preloaded fifo contents
// - trigger input is active low
// - reset clears control/status register
module dtf_seq #(
  parameter int DEPTH = dtf_pkg::FIFO_DEPTH,
  parameter int AW = dtf_pkg::FIFO_AW
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [7:0] addr_in, // register byte address
  input wire logic [31:0] wdata_in,
  input wire logic wr_in, // one cycle write strobe
  input wire logic rd_in, // one cycle read strobe
  output logic [31:0] rdata_out, // valid the cycle after rd_in
  input wire logic trig_n_in, // external trigger pin, async
  output logic trig_n_out, // trigger pin drive value
  output logic trig_oe_out, // high while driving the trigger pin
  output logic [8*dtf_pkg::SMP_DATA_W-1:0] dac_out, // eight channel codes
  output logic dac_load_out, // one cycle pulse, new codes applied
  output logic irq_out // below-threshold interrupt, level
);
  // only a 10 bit pointer over 1024 words is served
  if (DEPTH != (1 << AW) || AW != dtf_pkg::FIFO_AW) begin : g_bad_param
    $error("dtf_seq: DEPTH must be 2**AW with AW of 10");
  end

  localparam int DW = dtf_pkg::SMP_DATA_W;

  // all registered state of the sequencer
  typedef struct packed {
    logic [1:0] mode; // control: conversion mode
    logic [1:0] trig_sel; // control: trigger direction
    logic irq_en; // control: interrupt enable
    logic [9:0] thresh; // refill level
    logic [7:0] pre; // prescaler divisor
    logic [15:0] ctm; // conversion timer divisor
    logic [AW-1:0] wp; // write pointer
    logic [AW-1:0] rp; // pop pointer
    logic [AW-1:0] rcp; // recycle pointer
    logic [AW:0] cnt; // fill level
    dtf_pkg::dtf_state_e st; // sequencer state
    logic [4:0] frac; // 8 MHz fractional accumulator
    logic [7:0] pre_cnt; // prescaler count
    logic [15:0] ctm_cnt; // conversion timer count
    logic [2:0] sync; // trigger synchroniser and edge stage
    logic [7:0][DW-1:0] shadow; // codes gathered this cycle
    logic [7:0][DW-1:0] dac; // codes on the converters
    logic load; // apply pulse
    logic trig_n; // trigger pin drive
    logic trig_oe; // trigger pin enable
    logic irq; // interrupt line
    logic [31:0] rdata; // read answer
  } dtf_seq_s;

  dtf_seq_s q; // current state
  dtf_seq_s next_q; // next state

  logic [dtf_pkg::SMP_W-1:0] mem_rdata; // popped sample
  logic mem_we; // fifo push into memory
  logic mem_re; // fifo read into memory
  logic [AW-1:0] mem_raddr; // read address

  // combinational helpers
  logic push; // accepted host write
  logic pop; // consumed sample (not in recycle)
  logic full;
  logic empty;
  logic below;
  logic recycle;
  logic avail; // a sample may be read this cycle
  logic sw_start;
  logic ext_edge;
  logic start;
  logic tick8; // 8 MHz enable
  logic pre_wrap;
  logic conv_tick; // conversion timer expiry
  logic [4:0] frac_sum; // fractional sum before wrap
  // tag width kept local so the select below stays a plain constant
  localparam int SMP_TAG_W_L = dtf_pkg::SMP_TAG_W;
  logic [SMP_TAG_W_L-1:0] tag; // channel of the latched sample

  // fifo level flags; full leaves no room for one more push
  assign full = (q.cnt == (AW+1)'(DEPTH));
  assign empty = (q.cnt == '0);
  assign below = (q.cnt < {1'b0, q.thresh});
  assign recycle = (q.mode == dtf_pkg::MODE_RECYCLE);
  // host side push; dropped when the fifo is full
  assign push = wr_in && (addr_in == dtf_pkg::REG_FIFO) && !full;
  // software start: bit zero of a start write, other bits ignored
  assign sw_start = wr_in && (addr_in == dtf_pkg::REG_START) && wdata_in[dtf_pkg::START_BIT];
  // falling edge seen between stage two and three only, never stage one
  assign ext_edge = (q.trig_sel == dtf_pkg::TRIG_IN) && q.sync[2] && !q.sync[1];
  assign start = sw_start || ext_edge;
  // recycle replays addresses 0 up to the last written word
  assign avail = recycle ? (q.wp != '0) : !empty;
  // fetch only in the read state, so a sample is never taken twice
  assign mem_re = (q.st == dtf_pkg::ST_READ) && avail;
  assign pop = mem_re && !recycle;
  // recycle walks its own pointer and leaves the pop side untouched
  assign mem_raddr = recycle ? q.rcp : q.rp;
  // memory write port follows accepted pushes only
  assign mem_we = push;
  assign tag = mem_rdata[dtf_pkg::SMP_TAG_LSB +: SMP_TAG_W_L];

  // 8 MHz timer base, 2 ticks in every 25 clocks
  assign frac_sum = q.frac + dtf_pkg::FRAC_STEP;
  assign tick8 = (frac_sum >= dtf_pkg::FRAC_DEN);
  // divisor 0 behaves as 1: the compare already holds on the first tick
  assign pre_wrap = tick8 && ({1'b0, q.pre_cnt} + 9'h001 >= {1'b0, q.pre});
  assign conv_tick = pre_wrap && ({1'b0, q.ctm_cnt} + 17'h00001 >= {1'b0, q.ctm});

  // next state: registers, fifo pointers, timer and sequencer
  always_comb begin
    // pulsed outputs fall back to idle unless set below
    next_q = q;
    next_q.load = 1'b0;
    next_q.trig_n = 1'b1;
    next_q.rdata = 32'h0000_0000;
    next_q.sync = {q.sync[1:0], trig_n_in};
    next_q.frac = tick8 ? frac_sum - dtf_pkg::FRAC_DEN : frac_sum;

    // register writes
    if (wr_in) begin
      unique case (addr_in)
        dtf_pkg::REG_CTRL: begin
          next_q.mode = wdata_in[dtf_pkg::CTRL_MODE_LSB +: 2];
          next_q.trig_sel = wdata_in[dtf_pkg::CTRL_TRIG_LSB +: 2];
          next_q.irq_en = wdata_in[dtf_pkg::CTRL_IRQ_EN];
        end
        dtf_pkg::REG_THRESH: next_q.thresh = wdata_in[9:0];
        dtf_pkg::REG_PRESCALE: next_q.pre = wdata_in[7:0];
        dtf_pkg::REG_CONVTIM: next_q.ctm = wdata_in[15:0];
        default: ; // other offsets store nothing here
      endcase
    end

    // register reads, answered in the next cycle; unmapped reads give zero
    if (rd_in) begin
      // status bits are read only; a write to them stores nothing
      unique case (addr_in)
        dtf_pkg::REG_CTRL: begin
          next_q.rdata[dtf_pkg::CTRL_MODE_LSB +: 2] = q.mode;
          next_q.rdata[dtf_pkg::CTRL_TRIG_LSB +: 2] = q.trig_sel;
          next_q.rdata[dtf_pkg::CTRL_IRQ_EN] = q.irq_en;
          next_q.rdata[dtf_pkg::STAT_EMPTY] = empty;
          next_q.rdata[dtf_pkg::STAT_FULL] = full;
          next_q.rdata[dtf_pkg::STAT_BELOW] = below;
          next_q.rdata[dtf_pkg::STAT_RUN] = (q.st != dtf_pkg::ST_IDLE);
        end
        dtf_pkg::REG_THRESH: next_q.rdata[9:0] = q.thresh;
        dtf_pkg::REG_PRESCALE: next_q.rdata[7:0] = q.pre;
        dtf_pkg::REG_CONVTIM: next_q.rdata[15:0] = q.ctm;
        dtf_pkg::REG_COUNT: next_q.rdata[AW:0] = q.cnt;
        default: ; // write only and unmapped offsets read zero
      endcase
    end

    // fifo pointers; push and pop in one cycle leave the level alone
    if (push) begin
      next_q.wp = q.wp + 1'b1;
    end
    if (pop) begin
      next_q.rp = q.rp + 1'b1;
    end
    // recycle never pops, so the level keeps the preloaded count
    next_q.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    if (mem_re && recycle) begin
      next_q.rcp = (q.rcp + 1'b1 == q.wp) ? '0 : q.rcp + 1'b1;
    end

    // timer runs only between continuous cycles, restarts at each start
    if (q.st == dtf_pkg::ST_WAIT) begin
      if (pre_wrap) begin
        next_q.pre_cnt = 8'h00;
        next_q.ctm_cnt = conv_tick ? 16'h0000 : q.ctm_cnt + 16'h0001;
      end else if (tick8) begin
        next_q.pre_cnt = q.pre_cnt + 8'h01;
      end
    end else begin
      next_q.pre_cnt = 8'h00;
      next_q.ctm_cnt = 16'h0000;
    end

    // sequencer
    unique case (q.st)
      dtf_pkg::ST_IDLE: begin
        // single mode takes no timer, only starts
        // a start in off mode is dropped, not remembered for later
        if (start && q.mode != dtf_pkg::MODE_OFF) begin
          next_q.st = dtf_pkg::ST_READ;
          next_q.trig_n = 1'b0;
        end
      end
      dtf_pkg::ST_WAIT: begin
        // no trigger needed once running; timer starts each new cycle
        // a switch to single mode drops back to idle without a load
        if (q.mode == dtf_pkg::MODE_OFF || q.mode == dtf_pkg::MODE_SINGLE) begin
          next_q.st = dtf_pkg::ST_IDLE;
        end else if (conv_tick) begin
          next_q.st = dtf_pkg::ST_READ;
          next_q.trig_n = 1'b0;
        end
      end
      dtf_pkg::ST_READ: begin
        // a sample is fetched this cycle and lands in the latch state
        if (q.mode == dtf_pkg::MODE_OFF) begin
          next_q.st = dtf_pkg::ST_IDLE;
        end else if (avail) begin
          next_q.st = dtf_pkg::ST_LATCH;
        end else begin
          // fifo ran dry: apply what was gathered, the rest hold
          next_q.dac = q.shadow;
          next_q.load = 1'b1;
          next_q.st = (q.mode == dtf_pkg::MODE_SINGLE) ? dtf_pkg::ST_IDLE : dtf_pkg::ST_WAIT;
        end
      end
      dtf_pkg::ST_LATCH: begin
        // the sample fetched last cycle is now on the memory output
        next_q.shadow[tag] = mem_rdata[DW-1:0];
        if (q.mode == dtf_pkg::MODE_OFF) begin
          next_q.st = dtf_pkg::ST_IDLE;
        end else if (mem_rdata[dtf_pkg::SMP_EOS]) begin
          // all gathered codes reach the converters together
          next_q.dac = next_q.shadow;
          next_q.load = 1'b1;
          next_q.st = (q.mode == dtf_pkg::MODE_SINGLE) ? dtf_pkg::ST_IDLE : dtf_pkg::ST_WAIT;
        end else begin
          next_q.st = dtf_pkg::ST_READ;
        end
      end
    endcase

    // trigger pin drive and interrupt line
    // a released pin is always left high so the shared line idles
    next_q.trig_oe = (next_q.trig_sel == dtf_pkg::TRIG_OUT);
    if (!next_q.trig_oe) begin
      next_q.trig_n = 1'b1;
    end
    next_q.irq = next_q.irq_en && (next_q.cnt < {1'b0, next_q.thresh});
  end

  // state register; reset clears control, status and outputs
  // synchroniser resets high like the idle pin, so no false edge follows
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      q <= '0;
      q.mode <= dtf_pkg::CTRL_RST;
      q.trig_sel <= dtf_pkg::CTRL_RST;
      q.thresh <= dtf_pkg::THRESH_RST;
      q.pre <= dtf_pkg::PRESCALE_RST;
      q.ctm <= dtf_pkg::CONVTIM_RST;
      q.st <= dtf_pkg::ST_IDLE;
      q.sync <= 3'h7;
      q.trig_n <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  // sample memory of the output fifo
  // read address switches between the pop and recycle pointers
  dtf_mem #(
    .WIDTH(dtf_pkg::SMP_W),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_mem (
    .clk_in(clk_in),
    .we_in(mem_we),
    .waddr_in(q.wp),
    .wdata_in(wdata_in[dtf_pkg::SMP_W-1:0]),
    .re_in(mem_re),
    .raddr_in(mem_raddr),
    .rdata_out(mem_rdata)
  );

  // outputs straight from the state register
  // no logic between the register and the pins
  assign rdata_out = q.rdata;
  assign trig_n_out = q.trig_n;
  assign trig_oe_out = q.trig_oe;
  assign dac_out = q.dac;
  assign dac_load_out = q.load;
  assign irq_out = q.irq;
endmodule : dtf_seq
`default_nettype wire

// file: tb/dtf_seq_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// port-level checks for the sequencer
module dtf_seq_monitor (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [31:0] rdata_out,
  input wire logic trig_n_in,
  input wire logic trig_n_out,
  input wire logic trig_oe_out,
  input wire logic [127:0] dac_out,
  input wire logic dac_load_out,
  input wire logic irq_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);
  // codes may move only together with the load pulse
  a_dac_hold: assert property (!dac_load_out |-> $stable(dac_out))
    else $error("dac codes moved without a load");
  // a dry fifo ends a cycle after one read, so loads are at least two apart
  a_load_gap: assert property (dac_load_out |=> !dac_load_out)
    else $error("load pulses too close");
  a_rd_quiet: assert property (!rd_in |=> rdata_out == 32'h0000_0000)
    else $error("read data outside its slot");
  a_rd_unmap: assert property (rd_in && addr_in == 8'hFC |=> rdata_out == 32'h0000_0000)
    else $error("unmapped read not zero");
  // pin left high whenever the block does not own it
  a_trig_idle: assert property (!trig_oe_out |-> trig_n_out)
    else $error("trigger driven low while released");
  a_trig_pulse: assert property ($fell(trig_n_out) |=> trig_n_out)
    else $error("trigger out pulse too long");
  // off mode stops traffic; a quiet bus after it means no new mode can start
  a_off_quiet: assert property ((wr_in && addr_in == dtf_pkg::REG_CTRL
    && wdata_in[1:0] == dtf_pkg::MODE_OFF) ##1 (!wr_in [*6]) |-> (!dac_load_out [*4]))
    else $error("load after conversions disabled");
  a_flags_excl: assert property (rd_in && addr_in == dtf_pkg::REG_CTRL
    |=> !(rdata_out[dtf_pkg::STAT_EMPTY] && rdata_out[dtf_pkg::STAT_FULL]))
    else $error("fifo empty and full together");
  c_load: cover property (dac_load_out);
  c_trig_out: cover property (!trig_n_out);
  c_irq: cover property (irq_out);
  c_run: cover property (rd_in && addr_in == dtf_pkg::REG_CTRL ##1 rdata_out[15]);
endmodule : dtf_seq_monitor
bind dtf_seq dtf_seq_monitor mon_u (.clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .trig_n_in(trig_n_in), .trig_n_out(trig_n_out), .trig_oe_out(trig_oe_out),
  .dac_out(dac_out), .dac_load_out(dac_load_out), .irq_out(irq_out));
`default_nettype wire

// file: tb/dtf_dac_model.sv
`timescale 1ns/10ps
`default_nettype none
// eight converter channels; counts loads and spacing between them
module dtf_dac_model (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [127:0] dac_in,
  input wire logic load_in,
  output logic [127:0] code_out,
  output int loads_out,
  output int gap_out
);
  int since; // cycles since last load
  // channels convert only at the load, all at once, else hold
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      code_out <= 128'h0;
      loads_out <= 0;
      gap_out <= 0;
      since <= 0;
    end else if (load_in) begin
      code_out <= dac_in;
      loads_out <= loads_out + 1;
      gap_out <= since + 1;
      since <= 0;
    end else begin
      since <= since + 1;
    end
  end
endmodule : dtf_dac_model
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic clk, nrst, wr, rd, trig_drv, trig_n, trig_oe, load, irq;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic [127:0] dac, code;
  int err_total, compares, loads, gap, i, pulses; // pulses: output trigger lows seen
  wire logic trig_pin;
  // pin level: block drives when enabled, else our source
  assign trig_pin = trig_oe ? trig_n : trig_drv;
  dtf_seq dut_u (.clk_in(clk), .nrst_in(nrst), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
    .rd_in(rd), .rdata_out(rdata), .trig_n_in(trig_pin), .trig_n_out(trig_n),
    .trig_oe_out(trig_oe), .dac_out(dac), .dac_load_out(load), .irq_out(irq));
  dtf_dac_model dac_u (.clk_in(clk), .nrst_in(nrst), .dac_in(dac), .load_in(load),
    .code_out(code), .loads_out(loads), .gap_out(gap));
  // free running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // counts cycles in which the block drives the trigger pin low
  always @(posedge clk) begin
    if (trig_oe && !trig_n) begin
      pulses++;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one strobe cycle, then a quiet edge before the next request
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  // data stands only in the cycle after the strobe edge
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata & m, exp);
  endtask : rd_reg
  task automatic push(input logic [2:0] tag, input logic [15:0] d, input logic eos);
    wr_reg(dtf_pkg::REG_FIFO, {12'h000, eos, tag, d});
  endtask : push
  task automatic chan(input int ch, input logic [15:0] exp);
    chk({16'h0000, code[16*ch +: 16]}, {16'h0000, exp});
  endtask : chan
  // bounded wait; running out ends the run
  task automatic wait_loads(input int n);
    int k;
    for (k = 0; k < 3000 && loads < n; k++) @(posedge clk);
    if (loads < n) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, loads, n);
      give_verdict();
    end
  endtask : wait_loads
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict
  initial begin
    {nrst, wr, rd, addr, wdata} = '0;
    trig_drv = 1'b1;
    err_total = 0;
    compares = 0;
    pulses = 0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    // empty flag is left out of the reset compare
    rd_reg(dtf_pkg::REG_CTRL, 32'h0, 32'hFFFF_EFFF);
    rd_reg(8'hFC, 32'h0, ALL);
    $display("test 1 done");
    // single mode, output trigger, irq on
    wr_reg(dtf_pkg::REG_THRESH, 32'h4);
    wr_reg(dtf_pkg::REG_CTRL, 32'h19);
    push(3'h2, 16'hA1A1, 1'b0);
    push(3'h5, 16'hB2B2, 1'b1);
    push(3'h0, 16'hC3C3, 1'b1);
    rd_reg(dtf_pkg::REG_COUNT, 32'h3, ALL);
    rd_reg(dtf_pkg::REG_CTRL, 32'h4019, ALL);
    chk(irq, 1'b1);
    chk(trig_oe, 1'b1);
    wr_reg(dtf_pkg::REG_PRESCALE, 32'h1);
    wr_reg(dtf_pkg::REG_CONVTIM, 32'h1);
    wr_reg(dtf_pkg::REG_START, 32'h1);
    wait_loads(1);
    chan(2, 16'hA1A1);
    chan(5, 16'hB2B2);
    chan(0, 16'h0000);
    repeat (300) @(posedge clk);
    chk(loads, 1);
    wr_reg(dtf_pkg::REG_START, 32'h1);
    wait_loads(2);
    chan(0, 16'hC3C3);
    chan(2, 16'hA1A1);
    chk(pulses, 2);
    $display("test 2 done");
    // external trigger, held low for many cycles
    wr_reg(dtf_pkg::REG_CTRL, 32'h05);
    push(3'h7, 16'hD4D4, 1'b1);
    chk(trig_oe, 1'b0);
    trig_drv <= 1'b0;
    repeat (10) @(posedge clk);
    trig_drv <= 1'b1;
    wait_loads(3);
    repeat (50) @(posedge clk);
    chk(loads, 3);
    chan(7, 16'hD4D4);
    $display("test 3 done");
    // continuous: 2*4/8 us is 100 clocks between cycles
    wr_reg(dtf_pkg::REG_PRESCALE, 32'h2);
    wr_reg(dtf_pkg::REG_CONVTIM, 32'h4);
    wr_reg(dtf_pkg::REG_CTRL, 32'h02);
    push(3'h1, 16'hE5E5, 1'b1);
    push(3'h3, 16'hF6F6, 1'b1);
    wr_reg(dtf_pkg::REG_START, 32'h1);
    wait_loads(5);
    // 100 clocks less up to one 8 MHz tick of phase, then read, latch, load
    chk(gap >= 90 && gap <= 103, 1'b1);
    rd_reg(dtf_pkg::REG_CTRL, 32'hD002, ALL);
    chan(1, 16'hE5E5);
    chan(3, 16'hF6F6);
    wait_loads(6);
    chan(1, 16'hE5E5);
    wr_reg(dtf_pkg::REG_CTRL, 32'h00);
    repeat (300) @(posedge clk);
    chk(loads, 6);
    rd_reg(dtf_pkg::REG_CTRL, 32'h5000, ALL);
    $display("test 4 done");
    // fill to the brim, one extra push is dropped
    for (i = 0; i < 1024; i++) push(3'h0, i[15:0], 1'b1);
    rd_reg(dtf_pkg::REG_COUNT, 32'h400, ALL);
    rd_reg(dtf_pkg::REG_CTRL, 32'h2000, ALL);
    push(3'h1, 16'h1234, 1'b1);
    rd_reg(dtf_pkg::REG_COUNT, 32'h400, ALL);
    $display("test 5 done");
    // recycle: write pointer wrapped to 6, addresses 0..5 hold pushes 1018..1023
    wr_reg(dtf_pkg::REG_CTRL, 32'h03);
    wr_reg(dtf_pkg::REG_START, 32'h1);
    wait_loads(7);
    chan(0, 16'h03FA);
    wait_loads(8);
    chan(0, 16'h03FB);
    wait_loads(13);
    chan(0, 16'h03FA);
    rd_reg(dtf_pkg::REG_COUNT, 32'h400, ALL);
    wr_reg(dtf_pkg::REG_CTRL, 32'h00);
    repeat (300) @(posedge clk);
    chk(loads, 13);
    $display("test 6 done");
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
